// [src/lw_lockup_watchdog.sv]
// Windowed lockup watchdog with an AXI4-Lite register slave
`timescale 1ns/1ps
`include "lw_consts.svh"

module lw_lockup_watchdog (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic low_speed_internal_osc_in,
	input wire logic low_speed_external_osc_in,
	input wire logic debug_halt_in,
	output logic sys_reset_out
);

	// ****************************************************************
	// Decoding helpers
	// ****************************************************************
	function automatic lw_pkg::lw_reg_t reg_sel(input logic [7:0] a);
		case (a)
			`LW_OFF_CTRL: reg_sel = lw_pkg::LW_R_CTRL;
			`LW_OFF_MODE: reg_sel = lw_pkg::LW_R_MODE;
			`LW_OFF_LIMIT: reg_sel = lw_pkg::LW_R_LIMIT;
			`LW_OFF_PROT: reg_sel = lw_pkg::LW_R_PROT;
			`LW_OFF_STAT: reg_sel = lw_pkg::LW_R_STAT;
			default: reg_sel = lw_pkg::LW_R_NONE;
		endcase
	endfunction

	function automatic logic [31:0] merge(
		input logic [31:0] old_w,
		input logic [31:0] new_w,
		input logic [3:0] strb
	);
		logic [31:0] m;
		m = old_w;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				m[b*8 +: 8] = new_w[b*8 +: 8];
			end
		end
		return m;
	endfunction

	// ****************************************************************
	// Watchdog state
	// ****************************************************************
	logic enabled, stop_in_debug, protect, flag_under, flag_early;
	lw_pkg::lw_clk_cfg_t clk_cfg;
	logic [`LW_CNT_W-1:0] reload_val, delta, count;
	logic [3:0] hold_cnt;

	logic next_enabled, next_stop_in_debug, next_protect;
	logic next_flag_under, next_flag_early, next_sys_reset;
	lw_pkg::lw_clk_cfg_t next_clk_cfg;
	logic [`LW_CNT_W-1:0] next_reload_val, next_delta, next_count;
	logic [3:0] next_hold_cnt;

	logic tick, run;

	// ****************************************************************
	// Bus slave state
	// ****************************************************************
	logic aw_held, w_held, bvalid, rvalid;
	logic [7:0] aw_addr;
	logic [31:0] w_data, rdata;
	logic [3:0] w_strb;
	logic [1:0] bresp, rresp;

	logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
	logic [7:0] next_aw_addr;
	logic [31:0] next_w_data, next_rdata;
	logic [3:0] next_w_strb;
	logic [1:0] next_bresp, next_rresp;

	logic do_write;
	lw_pkg::lw_reg_t wr_reg;
	logic [31:0] wr_word;

	// ****************************************************************
	// Register images seen by software
	// ****************************************************************
	function automatic logic [31:0] rd_word(input lw_pkg::lw_reg_t r);
		logic [31:0] w;
		w = 32'h00000000;
		case (r)
			lw_pkg::LW_R_MODE: begin
				w[`LW_MODE_EN_BIT] = enabled;
				w[`LW_MODE_STOP_BIT] = stop_in_debug;
				w[`LW_MODE_SRC_BIT] = clk_cfg.src;
				w[`LW_MODE_PSC_LSB +: `LW_PSC_W] = clk_cfg.prescale;
			end
			lw_pkg::LW_R_LIMIT: begin
				w[`LW_LIMIT_RELOAD_LSB +: `LW_CNT_W] = reload_val;
				w[`LW_LIMIT_DELTA_LSB +: `LW_CNT_W] = delta;
			end
			lw_pkg::LW_R_PROT: begin
				w[`LW_PROT_BIT] = protect;
			end
			lw_pkg::LW_R_STAT: begin
				w[`LW_STAT_CNT_LSB +: `LW_CNT_W] = count;
				w[`LW_STAT_UNDER_BIT] = flag_under;
				w[`LW_STAT_EARLY_BIT] = flag_early;
			end
			default: begin
				w = 32'h00000000;
			end
		endcase
		return w;
	endfunction

	// ****************************************************************
	// AXI4-Lite channels
	// ****************************************************************
	assign s_axi_awready_out = !aw_held && !bvalid;
	assign s_axi_wready_out = !w_held && !bvalid;
	assign s_axi_arready_out = !rvalid;
	assign s_axi_bvalid_out = bvalid;
	assign s_axi_bresp_out = bresp;
	assign s_axi_rvalid_out = rvalid;
	assign s_axi_rdata_out = rdata;
	assign s_axi_rresp_out = rresp;

	assign do_write = aw_held && w_held && !bvalid;
	assign wr_reg = reg_sel(aw_addr);

	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bresp = bresp;
		next_bvalid = bvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		next_rvalid = rvalid;
		if (s_axi_awvalid_in && s_axi_awready_out) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && s_axi_wready_out) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata_in;
			next_w_strb = s_axi_wstrb_in;
		end
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = (wr_reg == lw_pkg::LW_R_NONE) ?
				`LW_RESP_SLVERR : `LW_RESP_OKAY;
		end else if (bvalid && s_axi_bready_in) begin
			next_bvalid = 1'b0;
		end
		if (s_axi_arvalid_in && s_axi_arready_out) begin
			next_rvalid = 1'b1;
			next_rdata = rd_word(reg_sel(s_axi_araddr_in));
			next_rresp = (reg_sel(s_axi_araddr_in) ==
				lw_pkg::LW_R_NONE) ? `LW_RESP_SLVERR : `LW_RESP_OKAY;
		end else if (rvalid && s_axi_rready_in) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			bresp <= `LW_RESP_OKAY;
			bvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `LW_RESP_OKAY;
			rvalid <= 1'b0;
		end else begin
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held <= next_w_held;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bresp <= next_bresp;
			bvalid <= next_bvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
			rvalid <= next_rvalid;
		end
	end

	// ****************************************************************
	// Count tick source
	// ****************************************************************
	assign run = enabled && !(stop_in_debug && debug_halt_in);

	lw_tick_gen u_tick (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.low_speed_internal_osc_in(low_speed_internal_osc_in),
		.low_speed_external_osc_in(low_speed_external_osc_in),
		.cfg_in(clk_cfg),
		.run_in(run),
		.tick_out(tick)
	);

	// ****************************************************************
	// Watchdog core
	// ****************************************************************
	always_comb begin
		// Merged here so the word follows live register contents
		wr_word = merge(rd_word(wr_reg), w_data, w_strb);
		next_enabled = enabled;
		next_stop_in_debug = stop_in_debug;
		next_clk_cfg = clk_cfg;
		next_reload_val = reload_val;
		next_delta = delta;
		next_protect = protect;
		next_count = count;
		next_flag_under = flag_under;
		next_flag_early = flag_early;
		next_hold_cnt = hold_cnt;

		// Software writes; configuration is locked while protected
		if (do_write) begin
			case (wr_reg)
				lw_pkg::LW_R_MODE: begin
					if (!protect) begin
						next_enabled = wr_word[`LW_MODE_EN_BIT];
						next_stop_in_debug = wr_word[`LW_MODE_STOP_BIT];
						next_clk_cfg.src = wr_word[`LW_MODE_SRC_BIT];
						next_clk_cfg.prescale =
							wr_word[`LW_MODE_PSC_LSB +: `LW_PSC_W];
					end
				end
				lw_pkg::LW_R_LIMIT: begin
					if (!protect) begin
						next_reload_val =
							wr_word[`LW_LIMIT_RELOAD_LSB +: `LW_CNT_W];
						next_delta = wr_word[`LW_LIMIT_DELTA_LSB +: `LW_CNT_W];
					end
				end
				lw_pkg::LW_R_PROT: begin
					next_protect = (wr_word != `LW_UNLOCK_KEY);
				end
				lw_pkg::LW_R_STAT: begin
					if (wr_word[`LW_STAT_UNDER_BIT]) begin
						next_flag_under = 1'b0;
					end
					if (wr_word[`LW_STAT_EARLY_BIT]) begin
						next_flag_early = 1'b0;
					end
				end
				default: begin
					next_protect = protect;
				end
			endcase
		end

		// Counting, reloads and reset requests; flag sets beat clears
		if (!enabled) begin
			next_count = reload_val;
		end else if (do_write && wr_reg == lw_pkg::LW_R_CTRL &&
			wr_word[`LW_CTRL_KEY_LSB +: `LW_KEY_W] == `LW_RELOAD_KEY &&
			wr_word[`LW_CTRL_RELOAD_BIT]) begin
			if (count > delta) begin
				next_flag_early = 1'b1;
				next_hold_cnt = `LW_RST_HOLD;
			end
			next_count = reload_val;
		end else if (tick) begin
			if (count == '0) begin
				next_flag_under = 1'b1;
				next_hold_cnt = `LW_RST_HOLD;
				next_count = reload_val;
			end else begin
				next_count = count - 12'h001;
			end
		end

		if (hold_cnt != 4'h0 && next_hold_cnt == hold_cnt) begin
			next_hold_cnt = hold_cnt - 4'h1;
		end
		next_sys_reset = (next_hold_cnt != 4'h0);
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			enabled <= 1'b0;
			stop_in_debug <= 1'b0;
			clk_cfg <= '{src: 1'b0, prescale: `LW_PSC_RESET};
			reload_val <= `LW_CNT_RESET;
			delta <= `LW_DELTA_RESET;
			protect <= 1'b0;
			count <= `LW_CNT_RESET;
			flag_under <= 1'b0;
			flag_early <= 1'b0;
			hold_cnt <= 4'h0;
			sys_reset_out <= 1'b0;
		end else begin
			enabled <= next_enabled;
			stop_in_debug <= next_stop_in_debug;
			clk_cfg <= next_clk_cfg;
			reload_val <= next_reload_val;
			delta <= next_delta;
			protect <= next_protect;
			count <= next_count;
			flag_under <= next_flag_under;
			flag_early <= next_flag_early;
			hold_cnt <= next_hold_cnt;
			sys_reset_out <= next_sys_reset;
		end
	end

endmodule // lw_lockup_watchdog

// [src/lw_consts.svh]
// Offsets, field positions, keys and reset values of the lockup watchdog
`ifndef LW_CONSTS_SVH
`define LW_CONSTS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define LW_OFF_CTRL 8'h00
`define LW_OFF_MODE 8'h04
`define LW_OFF_LIMIT 8'h08
`define LW_OFF_PROT 8'h0C
`define LW_OFF_STAT 8'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define LW_CTRL_RELOAD_BIT 0
`define LW_CTRL_KEY_LSB 16
`define LW_MODE_EN_BIT 0
`define LW_MODE_STOP_BIT 1
`define LW_MODE_SRC_BIT 2
`define LW_MODE_PSC_LSB 4
`define LW_LIMIT_RELOAD_LSB 0
`define LW_LIMIT_DELTA_LSB 16
`define LW_PROT_BIT 0
`define LW_STAT_CNT_LSB 0
`define LW_STAT_UNDER_BIT 16
`define LW_STAT_EARLY_BIT 17

// ****************************************************************
// Widths, keys and reset values
// ****************************************************************
`define LW_CNT_W 12
`define LW_PSC_W 3
`define LW_DIV_W 7
`define LW_KEY_W 16
`define LW_RELOAD_KEY 16'h5FA0
`define LW_UNLOCK_KEY 32'h000035CA
`define LW_CNT_RESET 12'hFFF
`define LW_DELTA_RESET 12'hFFF
`define LW_PSC_RESET 3'h0
`define LW_RST_HOLD 4'h8
`define LW_RESP_OKAY 2'h0
`define LW_RESP_SLVERR 2'h2

`endif

// [src/lw_pkg.sv]
// Types shared by the lockup watchdog files
package lw_pkg;

	// ****************************************************************
	// Register selector and clock configuration
	// ****************************************************************
	typedef enum logic [2:0] {
		LW_R_CTRL,
		LW_R_MODE,
		LW_R_LIMIT,
		LW_R_PROT,
		LW_R_STAT,
		LW_R_NONE
	} lw_reg_t;

	typedef struct packed {
		logic src;
		logic [2:0] prescale;
	} lw_clk_cfg_t;

endpackage

// [src/lw_tick_gen.sv]
// Clock source select and prescaler producing watchdog count ticks
`timescale 1ns/1ps
`include "lw_consts.svh"

module lw_tick_gen (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic low_speed_internal_osc_in,
	input wire logic low_speed_external_osc_in,
	input wire lw_pkg::lw_clk_cfg_t cfg_in,
	input wire logic run_in,
	output logic tick_out
);

	// ****************************************************************
	// Divider mask: low bits set for a divide by two to the prescale
	// ****************************************************************
	function automatic logic [`LW_DIV_W-1:0] div_mask(
		input logic [`LW_PSC_W-1:0] p
	);
		logic [`LW_DIV_W-1:0] m;
		m = '0;
		for (int i = 0; i < `LW_DIV_W; i++) begin
			m[i] = (i < int'(p));
		end
		return m;
	endfunction

	logic src_now;
	logic prev;
	logic [`LW_DIV_W-1:0] cnt;
	logic next_prev;
	logic [`LW_DIV_W-1:0] next_cnt;
	logic next_tick;
	logic [`LW_DIV_W-1:0] mask;

	assign src_now = cfg_in.src ? low_speed_external_osc_in : low_speed_internal_osc_in;
	assign mask = div_mask(cfg_in.prescale);

	// ****************************************************************
	// Rising edges of the chosen oscillator feed the prescaler
	// ****************************************************************
	always_comb begin
		next_prev = src_now;
		next_cnt = cnt;
		next_tick = 1'b0;
		if (run_in && src_now && !prev) begin
			if ((cnt & mask) == mask) begin
				next_tick = 1'b1;
				next_cnt = '0;
			end else begin
				next_cnt = cnt + 7'h01;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prev <= 1'b0;
			cnt <= '0;
			tick_out <= 1'b0;
		end else begin
			prev <= next_prev;
			cnt <= next_cnt;
			tick_out <= next_tick;
		end
	end

endmodule // lw_tick_gen

// [test/lw_lockup_watchdog_chk.sv]
// Concurrent checks on the ports of the lockup watchdog
`timescale 1ns/1ps

module lw_chk (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic [1:0] s_axi_bresp_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic sys_reset_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	// ********************************
	// Register bus
	// ********************************
	w_answer_a: assert property (s_axi_awvalid_in && s_axi_awready_out &&
		s_axi_wvalid_in && s_axi_wready_out |=>
		!s_axi_bvalid_out ##1 s_axi_bvalid_out)
		else $error("write response not two cycles after handshake");
	b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
		s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write response dropped or changed before taken");
	b_block_a: assert property (s_axi_bvalid_out |->
		!s_axi_awready_out && !s_axi_wready_out)
		else $error("write accepted while response pending");
	r_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=>
		s_axi_rvalid_out)
		else $error("read data not one cycle after address");
	r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
		s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("read data dropped or changed before taken");
	r_block_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
		else $error("read accepted while data pending");

	// ********************************
	// System reset pulse
	// ********************************
	rst_pulse_a: assert property ($rose(sys_reset_out) |->
		sys_reset_out[*8] ##1 !sys_reset_out)
		else $error("system reset pulse not eight cycles long");

endmodule // lw_chk

bind lw_lockup_watchdog lw_chk u_chk (
	.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
	.s_axi_awvalid_in(s_axi_awvalid_in),
	.s_axi_awready_out(s_axi_awready_out),
	.s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
	.s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
	.s_axi_bready_in(s_axi_bready_in), .s_axi_arvalid_in(s_axi_arvalid_in),
	.s_axi_arready_out(s_axi_arready_out),
	.s_axi_rdata_out(s_axi_rdata_out), .s_axi_rvalid_out(s_axi_rvalid_out),
	.s_axi_rready_in(s_axi_rready_in), .sys_reset_out(sys_reset_out)
);

// [test/tb_top.sv]
// Register-level testbench of the lockup watchdog
`timescale 1ns/1ps
`include "lw_consts.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED %s expected %h seen %h", n, e, g); end end

module tb_top;
	localparam logic [1:0] OK = `LW_RESP_OKAY;
	localparam logic [1:0] ERR = `LW_RESP_SLVERR;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic osc_i = 1'b0;
	logic osc_e = 1'b0;
	logic halt = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, sys_rst;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int bad_count = 0;
	int compares = 0;
	int rst_ev = 0;

	lw_lockup_watchdog DUT (
		.clk_sys_in(clk), .rst_n_in(rst_n),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .low_speed_internal_osc_in(osc_i),
		.low_speed_external_osc_in(osc_e), .debug_halt_in(halt),
		.sys_reset_out(sys_rst)
	);

	initial begin
		forever #2.5 clk = ~clk;
	end

	always @(posedge sys_rst) rst_ev++;

	// ********************************
	// Bus and oscillator tasks
	// ********************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic a_ok, w_ok, ad, wd, b;
		logic [1:0] r;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		while (!(ad && wd)) begin
			@(negedge clk);
			a_ok = awvalid && awready;
			w_ok = wvalid && wready;
			@(posedge clk);
			if (a_ok) awvalid <= 1'b0;
			if (w_ok) wvalid <= 1'b0;
			ad |= a_ok;
			wd |= w_ok;
		end
		// Late ready lets the response wait two cycles
		repeat (3) @(posedge clk);
		bready <= 1'b1;
		do begin
			@(negedge clk);
			b = bvalid;
			r = bresp;
			@(posedge clk);
		end while (!b);
		bready <= 1'b0;
		`CHK("bresp", er, r)
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic ok;
		logic [31:0] d;
		logic [1:0] r;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge clk);
			ok = arready;
			@(posedge clk);
		end while (!ok);
		arvalid <= 1'b0;
		@(posedge clk);
		rready <= 1'b1;
		do begin
			@(negedge clk);
			ok = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
		end while (!ok);
		rready <= 1'b0;
		`CHK("rdata", ed, d)
		`CHK("rresp", er, r)
	endtask

	task automatic osc(input logic ext, input int n);
		repeat (n) begin
			osc_i <= !ext;
			osc_e <= ext;
			repeat (2) @(posedge clk);
			osc_i <= 1'b0;
			osc_e <= 1'b0;
			repeat (2) @(posedge clk);
		end
		repeat (4) @(posedge clk);
	endtask

	task automatic end_of_test;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ********************************
	// Tests
	// ********************************
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rd(`LW_OFF_MODE, 32'h0, OK);
		rd(`LW_OFF_LIMIT, 32'h0FFF0FFF, OK);
		rd(`LW_OFF_PROT, 32'h0, OK);
		rd(`LW_OFF_STAT, 32'h00000FFF, OK);
		rd(8'h20, 32'h0, ERR);
		wr(8'h20, 32'hFFFFFFFF, ERR);
		$display("test reset_values done");
		wr(`LW_OFF_LIMIT, 32'h00080010, OK);
		wr(`LW_OFF_MODE, 32'h00000001, OK);
		osc(1'b0, 3);
		rd(`LW_OFF_STAT, 32'h0000000D, OK);
		osc(1'b1, 3);
		rd(`LW_OFF_STAT, 32'h0000000D, OK);
		wr(`LW_OFF_MODE, 32'h00000005, OK);
		osc(1'b1, 2);
		rd(`LW_OFF_STAT, 32'h0000000B, OK);
		wr(`LW_OFF_MODE, 32'h00000015, OK);
		osc(1'b1, 4);
		rd(`LW_OFF_STAT, 32'h00000009, OK);
		$display("test count_and_source done");
		wr(`LW_OFF_CTRL, 32'h5FA00001, OK);
		repeat (2) @(posedge clk);
		`CHK("reset events", 1, rst_ev)
		rd(`LW_OFF_STAT, 32'h00020010, OK);
		wr(`LW_OFF_STAT, 32'h00020000, OK);
		rd(`LW_OFF_STAT, 32'h00000010, OK);
		$display("test early_reload done");
		wr(`LW_OFF_MODE, 32'h00000007, OK);
		halt <= 1'b1;
		osc(1'b1, 3);
		rd(`LW_OFF_STAT, 32'h00000010, OK);
		halt <= 1'b0;
		osc(1'b1, 8);
		rd(`LW_OFF_STAT, 32'h00000008, OK);
		wr(`LW_OFF_CTRL, 32'h5FA00001, OK);
		rd(`LW_OFF_STAT, 32'h00000010, OK);
		osc(1'b1, 16);
		`CHK("reset events", 1, rst_ev)
		osc(1'b1, 1);
		`CHK("reset events", 2, rst_ev)
		rd(`LW_OFF_STAT, 32'h00010010, OK);
		$display("test debug_and_underflow done");
		wr(`LW_OFF_PROT, 32'h00000001, OK);
		rd(`LW_OFF_PROT, 32'h00000001, OK);
		wr(`LW_OFF_LIMIT, 32'h00040020, OK);
		wr(`LW_OFF_MODE, 32'h00000000, OK);
		rd(`LW_OFF_LIMIT, 32'h00080010, OK);
		rd(`LW_OFF_MODE, 32'h00000007, OK);
		wr(`LW_OFF_PROT, 32'h000035CA, OK);
		wr(`LW_OFF_LIMIT, 32'h00040020, OK);
		rd(`LW_OFF_LIMIT, 32'h00040020, OK);
		wstrb <= 4'h3;
		wr(`LW_OFF_LIMIT, 32'hFFFF0030, OK);
		wstrb <= 4'hF;
		rd(`LW_OFF_LIMIT, 32'h00040030, OK);
		$display("test protection done");
		end_of_test;
	end

	// Roughly sixty times the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		end_of_test;
	end

endmodule // tb_top
